// file: src/cip_defines.vh
// Purpose: Constants for the component input processing block
// Assumes: Registers sit at 8-bit subaddresses on the serial control port
// Notes:   Offsets, field positions, reset values and pixel delay figures
`ifndef CIP_DEFINES_VH
`define CIP_DEFINES_VH

// Subaddresses
`define CIP_ADDR_INPUT_PORT_CLOCK_CONTROL 8'h23
`define CIP_ADDR_STATIC_GAIN_A_LOW        8'h24
`define CIP_ADDR_STATIC_GAIN_B_LOW        8'h25
`define CIP_ADDR_DELAY_AND_SWITCH_CONTROL 8'h29
`define CIP_ADDR_COMPONENT_BRIGHTNESS     8'h2a
`define CIP_ADDR_COMPONENT_CONTRAST       8'h2b

// Fields of input_port_clock_control
`define CIP_BIT_PORT_DRIVE_ENABLE   6
`define CIP_BIT_CLOCK_SOURCE_SELECT 5
`define CIP_BIT_CLAMP_REFERENCE     4
`define CIP_BIT_SWITCH_IND_ENABLE   2
`define CIP_BIT_GAIN_B_MSB          1
`define CIP_BIT_GAIN_A_MSB          0

// Fields of delay_and_switch_control
`define CIP_BIT_PIXEL_SWITCH_ENABLE   7
`define CIP_BIT_PIXEL_SWITCH_POLARITY 6
`define CIP_FLD_SWITCH_DELAY_HI       5
`define CIP_FLD_SWITCH_DELAY_LO       4
`define CIP_BIT_LUMA_PEAKING          3
`define CIP_FLD_PATH_DELAY_HI         2
`define CIP_FLD_PATH_DELAY_LO         0

// Reset values
`define CIP_RST_INPUT_PORT_CLOCK_CONTROL 8'h00
`define CIP_RST_STATIC_GAIN_LOW          8'h90
`define CIP_RST_DELAY_AND_SWITCH_CONTROL 8'h00
`define CIP_RST_COMPONENT_BRIGHTNESS     8'h80
`define CIP_RST_COMPONENT_CONTRAST       8'h40

// Pixel alignment: composite tap is fixed, others move around it
`define CIP_TAP_BASE      5'h12
`define CIP_BRIGHT_NOMINAL 17'sh00080
`define CIP_CONTRAST_SHIFT 6

`endif

// file: src/cip_delay.v
// Purpose: Pixel delay line with a selectable tap
// Assumes: Advances one pixel on each cycle where adv_i is high
// Notes:   Tap 0 returns the newest stored pixel
`timescale 1ns/1ps
module cip_delay #(
	parameter W  = 8,
	parameter D  = 32,
	parameter AW = 5
) (
	input  wire          clk_sys_i,
	input  wire          rst_n_i,
	input  wire          adv_i,
	input  wire [W-1:0]  din_i,
	input  wire [AW-1:0] tap_i,
	output wire [W-1:0]  dout_o
);
	reg [W-1:0] mem [0:D-1];
	integer     k;

	// Shift chain, cleared by reset
	always @(posedge clk_sys_i) begin
		for (k = 0; k < D; k = k + 1) begin
			if (!rst_n_i)
				mem[k] <= {W{1'b0}};
			else if (adv_i)
				mem[k] <= (k == 0) ? din_i : mem[k-1];
		end
	end

	assign dout_o = mem[tap_i];
endmodule

// file: src/cip_fifo.v
// Purpose: Small output FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two equal to 2**AW
// Notes:   Level is exported so the source side can stall ahead of time
`timescale 1ns/1ps
module cip_fifo #(
	parameter W     = 9,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire          clk_sys_i,
	input  wire          rst_n_i,
	input  wire          in_valid_i,
	output wire          in_ready_o,
	input  wire [W-1:0]  in_data_i,
	output wire          out_valid_o,
	input  wire          out_ready_i,
	output wire [W-1:0]  out_data_o,
	output reg  [AW:0]   level_o
);
	reg  [W-1:0]  mem [0:DEPTH-1];
	reg  [AW-1:0] wr_ptr;
	reg  [AW-1:0] rd_ptr;
	wire          push;
	wire          pop;

	assign in_ready_o  = (level_o != DEPTH[AW:0]);
	assign out_valid_o = (level_o != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Storage
	always @(posedge clk_sys_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	// Pointers and fill level
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wr_ptr  <= {AW{1'b0}};
			rd_ptr  <= {AW{1'b0}};
			level_o <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				level_o <= level_o + 1'b1;
			else if (pop && !push)
				level_o <= level_o - 1'b1;
		end
	end
endmodule

// file: src/cip_component_input.v
// Purpose: Component input control and pixel path with fast switching
// Assumes: All inputs synchronous to clk_sys_i; one pixel per accepted beat
// Notes:   Registers reached through the subaddress port; output via FIFO
//
// Contract
// - The converter data port is driven only while its enable bit is set, else released.
// - Converters take the line-locked clock when the select bit is 0, the external pin when 1.
// - Clamping follows the decoder clamp mode when the bit is 0, reference selection when 1.
// - With its enable set, any edge on the source-switch input resets the gain loop.
// - Gain A is a 9-bit code from control bit 0 and the gain A low byte.
// - Gain B is a 9-bit code from control bit 1 and the gain B low byte.
// - With switching enabled each pixel picks composite or component, else composite only.
// - Polarity 0 maps switch low to composite and high to component; 1 inverts it.
// - The switch input is shifted by 0, +1, -2 or -1 pixels relative to component.
// - The peaking bit adds luminance peaking to the component path, else bypass.
// - Component is delayed by 0,+4,+8,+12,-16,-12,-8,-4 pixels relative to composite.
// - An unsigned brightness offset with 128 as nominal is added to component luminance.
// - Component luminance is scaled by a signed contrast gain in 1/64 steps.
`timescale 1ns/1ps
`include "cip_defines.vh"
module cip_component_input #(
	parameter PW    = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire          clk_sys_i,
	input  wire          rst_n_i,
	// Subaddress register port
	input  wire          reg_wr_i,
	input  wire          reg_rd_i,
	input  wire [7:0]    reg_addr_i,
	input  wire [7:0]    reg_wdata_i,
	output reg  [7:0]    reg_rdata_o,
	output reg           reg_rack_o,
	// Converter side
	input  wire [8:0]    conv_raw_i,
	output reg  [8:0]    conv_port_data_o,
	output reg           conv_port_oe_o,
	input  wire          line_locked_clock_i,
	input  wire          external_sample_clock_pin_i,
	output reg           conv_clock_o,
	input  wire          decoder_clamp_mode_i,
	output reg           conv_clamp_o,
	output reg           conv_ref_select_o,
	input  wire          source_switch_indicator_input_i,
	output reg           gain_loop_reset_o,
	output wire [8:0]    gain_a_o,
	output wire [8:0]    gain_b_o,
	// Pixel input stream
	input  wire          pix_in_valid_i,
	output reg           pix_in_ready_o,
	input  wire [PW-1:0] cvbs_luma_i,
	input  wire [PW-1:0] comp_luma_i,
	input  wire          pixel_switch_input_i,
	// Pixel output stream
	output reg           pix_out_valid_o,
	input  wire          pix_out_ready_i,
	output reg  [PW-1:0] pix_out_data_o,
	output reg           pix_out_from_comp_o
);
	// Register file
	reg [7:0] input_port_clock_control;
	reg [7:0] static_gain_a_low;
	reg [7:0] static_gain_b_low;
	reg [7:0] delay_and_switch_control;
	reg [7:0] component_brightness;
	reg [7:0] component_contrast;
	reg [7:0] next_rdata;

	// Pixel path
	reg                 indicator_prev;
	reg  [PW-1:0]       comp_h0;
	reg  [PW-1:0]       comp_h1;
	reg  [PW-1:0]       cvbs_s1;
	reg                 sw_s1;
	reg  [4:0]          comp_tap;
	reg  [4:0]          sw_tap;
	wire [PW-1:0]       comp_dly;
	wire [PW-1:0]       cvbs_dly;
	wire                sw_dly;
	wire                adv;
	wire                fifo_in_ready;
	wire                fifo_out_valid;
	wire [PW:0]         fifo_out_data;
	wire [AW:0]         fifo_level;
	wire                fifo_pop;
	reg  signed [16:0]  peak_sum;
	reg  [PW-1:0]       luma_pk;
	reg  signed [16:0]  luma_bc;
	reg  [PW-1:0]       comp_out;
	reg                 use_comp;
	reg  [PW:0]         push_data;
	wire [AW+1:0]       next_level;

	// Clip a signed intermediate to the 8-bit pixel range
	function [7:0] sat8;
		input signed [16:0] v;
		begin
			if (v < 17'sd0)
				sat8 = 8'h00;
			else if (v > 17'sd255)
				sat8 = 8'hff;
			else
				sat8 = v[7:0];
		end
	endfunction

	// Register writes
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			input_port_clock_control <= `CIP_RST_INPUT_PORT_CLOCK_CONTROL;
			static_gain_a_low        <= `CIP_RST_STATIC_GAIN_LOW;
			static_gain_b_low        <= `CIP_RST_STATIC_GAIN_LOW;
			delay_and_switch_control <= `CIP_RST_DELAY_AND_SWITCH_CONTROL;
			component_brightness     <= `CIP_RST_COMPONENT_BRIGHTNESS;
			component_contrast       <= `CIP_RST_COMPONENT_CONTRAST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `CIP_ADDR_INPUT_PORT_CLOCK_CONTROL)
				input_port_clock_control <= reg_wdata_i;
			else if (reg_addr_i == `CIP_ADDR_STATIC_GAIN_A_LOW)
				static_gain_a_low <= reg_wdata_i;
			else if (reg_addr_i == `CIP_ADDR_STATIC_GAIN_B_LOW)
				static_gain_b_low <= reg_wdata_i;
			else if (reg_addr_i == `CIP_ADDR_DELAY_AND_SWITCH_CONTROL)
				delay_and_switch_control <= reg_wdata_i;
			else if (reg_addr_i == `CIP_ADDR_COMPONENT_BRIGHTNESS)
				component_brightness <= reg_wdata_i;
			else if (reg_addr_i == `CIP_ADDR_COMPONENT_CONTRAST)
				component_contrast <= reg_wdata_i;
		end
	end

	// Read decode; unmapped subaddresses read zero
	always @* begin
		if (reg_addr_i == `CIP_ADDR_INPUT_PORT_CLOCK_CONTROL)
			next_rdata = input_port_clock_control;
		else if (reg_addr_i == `CIP_ADDR_STATIC_GAIN_A_LOW)
			next_rdata = static_gain_a_low;
		else if (reg_addr_i == `CIP_ADDR_STATIC_GAIN_B_LOW)
			next_rdata = static_gain_b_low;
		else if (reg_addr_i == `CIP_ADDR_DELAY_AND_SWITCH_CONTROL)
			next_rdata = delay_and_switch_control;
		else if (reg_addr_i == `CIP_ADDR_COMPONENT_BRIGHTNESS)
			next_rdata = component_brightness;
		else if (reg_addr_i == `CIP_ADDR_COMPONENT_CONTRAST)
			next_rdata = component_contrast;
		else
			next_rdata = 8'h00;
	end

	// Read answer one cycle after the strobe
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
			reg_rack_o  <= 1'b0;
		end else begin
			reg_rack_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= next_rdata;
		end
	end

	// Static gains: msb from control register, low byte from own register
	assign gain_a_o = {input_port_clock_control[`CIP_BIT_GAIN_A_MSB], static_gain_a_low};
	assign gain_b_o = {input_port_clock_control[`CIP_BIT_GAIN_B_MSB], static_gain_b_low};

	// Converter port, clock choice, clamp choice and gain loop reset
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			conv_port_data_o  <= 9'h000;
			conv_port_oe_o    <= 1'b0;
			conv_clock_o      <= 1'b0;
			conv_clamp_o      <= 1'b0;
			conv_ref_select_o <= 1'b0;
			indicator_prev    <= 1'b0;
			gain_loop_reset_o <= 1'b0;
		end else begin
			conv_port_data_o <= conv_raw_i;
			conv_port_oe_o   <= input_port_clock_control[`CIP_BIT_PORT_DRIVE_ENABLE];
			conv_clock_o     <= input_port_clock_control[`CIP_BIT_CLOCK_SOURCE_SELECT] ?
				external_sample_clock_pin_i : line_locked_clock_i;
			conv_ref_select_o <= input_port_clock_control[`CIP_BIT_CLAMP_REFERENCE];
			conv_clamp_o      <= input_port_clock_control[`CIP_BIT_CLAMP_REFERENCE] ?
				1'b0 : decoder_clamp_mode_i;
			indicator_prev    <= source_switch_indicator_input_i;
			gain_loop_reset_o <= input_port_clock_control[`CIP_BIT_SWITCH_IND_ENABLE] &
				(indicator_prev ^ source_switch_indicator_input_i);
		end
	end

	// Tap selection: composite sits at the base tap, others around it
	always @* begin
		case (delay_and_switch_control[`CIP_FLD_PATH_DELAY_HI:`CIP_FLD_PATH_DELAY_LO])
			3'h0: comp_tap = `CIP_TAP_BASE;
			3'h1: comp_tap = `CIP_TAP_BASE + 5'h04;
			3'h2: comp_tap = `CIP_TAP_BASE + 5'h08;
			3'h3: comp_tap = `CIP_TAP_BASE + 5'h0c;
			3'h4: comp_tap = `CIP_TAP_BASE - 5'h10;
			3'h5: comp_tap = `CIP_TAP_BASE - 5'h0c;
			3'h6: comp_tap = `CIP_TAP_BASE - 5'h08;
			default: comp_tap = `CIP_TAP_BASE - 5'h04;
		endcase
		case (delay_and_switch_control[`CIP_FLD_SWITCH_DELAY_HI:`CIP_FLD_SWITCH_DELAY_LO])
			2'h0: sw_tap = comp_tap;
			2'h1: sw_tap = comp_tap + 5'h01;
			2'h2: sw_tap = comp_tap - 5'h02;
			default: sw_tap = comp_tap - 5'h01;
		endcase
	end

	// Pipeline advances when a pixel is offered and the FIFO has room
	assign adv = pix_in_valid_i & pix_in_ready_o & fifo_in_ready;

	cip_delay #(.W(PW), .D(32), .AW(5)) u_cvbs_dly (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.adv_i     (adv),
		.din_i     (cvbs_luma_i),
		.tap_i     (`CIP_TAP_BASE),
		.dout_o    (cvbs_dly)
	);

	cip_delay #(.W(PW), .D(32), .AW(5)) u_comp_dly (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.adv_i     (adv),
		.din_i     (comp_luma_i),
		.tap_i     (comp_tap),
		.dout_o    (comp_dly)
	);

	cip_delay #(.W(1), .D(32), .AW(5)) u_sw_dly (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.adv_i     (adv),
		.din_i     (pixel_switch_input_i),
		.tap_i     (sw_tap),
		.dout_o    (sw_dly)
	);

	// Neighbour history for peaking; composite and switch kept in step
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			comp_h0 <= {PW{1'b0}};
			comp_h1 <= {PW{1'b0}};
			cvbs_s1 <= {PW{1'b0}};
			sw_s1   <= 1'b0;
		end else if (adv) begin
			comp_h0 <= comp_dly;
			comp_h1 <= comp_h0;
			cvbs_s1 <= cvbs_dly;
			sw_s1   <= sw_dly;
		end
	end

	// Peaking, contrast, brightness and per-pixel source choice
	always @* begin
		peak_sum = $signed({9'h000, comp_h0}) +
			(($signed({8'h00, comp_h0, 1'b0}) - $signed({9'h000, comp_h1}) -
			$signed({9'h000, comp_dly})) >>> 3);
		if (delay_and_switch_control[`CIP_BIT_LUMA_PEAKING])
			luma_pk = sat8(peak_sum);
		else
			luma_pk = comp_h0;
		luma_bc = (($signed({9'h000, luma_pk}) *
			$signed({{9{component_contrast[7]}}, component_contrast})) >>>
			`CIP_CONTRAST_SHIFT)
			+ $signed({9'h000, component_brightness}) - `CIP_BRIGHT_NOMINAL;
		comp_out = sat8(luma_bc);
		use_comp = delay_and_switch_control[`CIP_BIT_PIXEL_SWITCH_ENABLE] &
			(sw_s1 ^ delay_and_switch_control[`CIP_BIT_PIXEL_SWITCH_POLARITY]);
		push_data = use_comp ? {1'b1, comp_out} : {1'b0, cvbs_s1};
	end

	cip_fifo #(.W(PW + 1), .DEPTH(DEPTH), .AW(AW)) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (adv),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data),
		.level_o     (fifo_level)
	);

	// Output register drains the FIFO; ready reflects room after this cycle
	assign fifo_pop   = fifo_out_valid & (~pix_out_valid_o | pix_out_ready_i);
	assign next_level = {1'b0, fifo_level} + {{(AW+1){1'b0}}, adv} -
		{{(AW+1){1'b0}}, fifo_pop};

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pix_out_valid_o     <= 1'b0;
			pix_out_data_o      <= {PW{1'b0}};
			pix_out_from_comp_o <= 1'b0;
			pix_in_ready_o      <= 1'b0;
		end else begin
			pix_in_ready_o <= (next_level < DEPTH);
			if (fifo_pop) begin
				pix_out_valid_o     <= 1'b1;
				pix_out_data_o      <= fifo_out_data[PW-1:0];
				pix_out_from_comp_o <= fifo_out_data[PW];
			end else if (pix_out_ready_i) begin
				pix_out_valid_o <= 1'b0;
			end
		end
	end
endmodule

// file: tb/cip_component_input_properties.sv
// Purpose: Port-level properties of the component input block
// Assumes: One clock, synchronous active-low reset
// Notes:   Register fields are seen through the gain and control outputs
`timescale 1ns/1ps
module cip_props (
	input wire       clk_sys_i,
	input wire       rst_n_i,
	input wire       reg_wr_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire [7:0] reg_rdata_o,
	input wire       reg_rack_o,
	input wire [8:0] conv_raw_i,
	input wire [8:0] conv_port_data_o,
	input wire       conv_port_oe_o,
	input wire       decoder_clamp_mode_i,
	input wire       conv_clamp_o,
	input wire       conv_ref_select_o,
	input wire       source_switch_indicator_input_i,
	input wire       gain_loop_reset_o,
	input wire [8:0] gain_a_o,
	input wire [8:0] gain_b_o,
	input wire       pix_out_valid_o,
	input wire       pix_out_ready_i,
	input wire [7:0] pix_out_data_o,
	input wire       pix_out_from_comp_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// Gain codes follow the register writes one cycle later
	AST_GAIN_A_LOW: assert property (
		reg_wr_i && reg_addr_i == 8'h24 |=> gain_a_o[7:0] == $past(reg_wdata_i))
		else $error("gain a low byte not loaded");
	AST_GAIN_A_MSB: assert property (
		reg_wr_i && reg_addr_i == 8'h23 |=> gain_a_o[8] == $past(reg_wdata_i[0]))
		else $error("gain a top bit not loaded");
	AST_GAIN_B_LOW: assert property (
		reg_wr_i && reg_addr_i == 8'h25 |=> gain_b_o[7:0] == $past(reg_wdata_i))
		else $error("gain b low byte not loaded");
	AST_GAIN_B_MSB: assert property (
		reg_wr_i && reg_addr_i == 8'h23 |=> gain_b_o[8] == $past(reg_wdata_i[1]))
		else $error("gain b top bit not loaded");
	AST_READ_GAIN: assert property (
		reg_rd_i && !reg_wr_i && reg_addr_i == 8'h24 |=> reg_rack_o && reg_rdata_o == gain_a_o[7:0])
		else $error("gain a readback wrong");
	// Driven port carries the raw sample of the previous cycle
	AST_PORT_DATA: assert property (
		conv_port_oe_o && $past(rst_n_i) |-> conv_port_data_o == $past(conv_raw_i))
		else $error("converter port data wrong");
	AST_REF_NO_CLAMP: assert property (
		conv_ref_select_o |-> !conv_clamp_o)
		else $error("clamp active with reference select");
	AST_CLAMP_FOLLOW: assert property (
		!conv_ref_select_o && $past(rst_n_i) |-> conv_clamp_o == $past(decoder_clamp_mode_i))
		else $error("clamp does not follow decoder mode");
	// A gain loop reset needs a recent edge on the indicator
	AST_IND_EDGE: assert property (
		gain_loop_reset_o |-> $past(source_switch_indicator_input_i, 1) != $past(source_switch_indicator_input_i, 2) || $past(source_switch_indicator_input_i, 2) != $past(source_switch_indicator_input_i, 3) || $past(source_switch_indicator_input_i, 3) != $past(source_switch_indicator_input_i, 4))
		else $error("gain loop reset without indicator edge");
	AST_OUT_HOLD: assert property (
		pix_out_valid_o && !pix_out_ready_i |=> pix_out_valid_o && $stable(pix_out_data_o) && $stable(pix_out_from_comp_o))
		else $error("output pixel changed while stalled");

	COV_GLR: cover property (gain_loop_reset_o);
	COV_COMP: cover property (pix_out_valid_o && pix_out_from_comp_o);
	COV_STALL: cover property (pix_out_valid_o && !pix_out_ready_i);
endmodule

bind cip_component_input cip_props u_cip_props (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rack_o, .conv_raw_i, .conv_port_data_o,
	.conv_port_oe_o, .decoder_clamp_mode_i, .conv_clamp_o, .conv_ref_select_o,
	.source_switch_indicator_input_i, .gain_loop_reset_o, .gain_a_o, .gain_b_o,
	.pix_out_valid_o, .pix_out_ready_i, .pix_out_data_o, .pix_out_from_comp_o);

// file: tb/cip_conv_model.sv
// Purpose: Analog front-end stand-in feeding the component input block
// Assumes: Changes its outputs at the falling clock edge
// Notes:   Clock levels and clamp mode move at unrelated rates
`timescale 1ns/1ps
module cip_conv_model (
	input  wire       clk_sys_i,
	output reg  [8:0] conv_raw_o   = 9'h000,
	output reg        line_clock_o = 1'b0,
	output reg        ext_clock_o  = 1'b0,
	output reg        clamp_mode_o = 1'b0
);
	reg [7:0] cnt = 8'h00;

	// Samples change every cycle so a stuck port shows up
	always @(negedge clk_sys_i) begin
		cnt          <= cnt + 8'h01;
		conv_raw_o   <= {cnt[0], cnt} ^ 9'h0a5;
		line_clock_o <= cnt[1];
		ext_clock_o  <= cnt[2] ^ cnt[0];
		clamp_mode_o <= cnt[3];
	end
endmodule

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the component input block
// Assumes: Inputs change at the falling edge, sink mostly ready
// Notes:   Pixel checks use flat pictures so peaking adds nothing
`timescale 1ns/1ps
module tb_top;
	reg        clk_sys_i = 1'b0;
	reg        rst_n_i = 1'b0;
	reg        wr = 1'b0;
	reg        rd = 1'b0;
	reg  [7:0] addr = 8'h00;
	reg  [7:0] wdata = 8'h00;
	reg        ind = 1'b0;
	reg        vin = 1'b0;
	reg        sw = 1'b0;
	reg        ordy = 1'b1;
	reg        llc_q, ext_q, cm_q, last_c;
	reg  [7:0] last_d;
	wire [7:0] rdata, odata;
	wire [8:0] raw, gain_a, gain_b;
	wire       rack, oe, cclk, clamp, refsel, glr, irdy, oval, ocomp, llc, extc, cmode;
	integer    failures = 0;
	integer    total_checks = 0;
	integer    pulses = 0;
	integer    accepted = 0;
	integer    outs = 0;

	cip_conv_model u_cip_conv_model (.clk_sys_i(clk_sys_i), .conv_raw_o(raw),
		.line_clock_o(llc), .ext_clock_o(extc), .clamp_mode_o(cmode));
	cip_component_input u_cip_component_input (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .reg_rack_o(rack), .conv_raw_i(raw), .conv_port_data_o(),
		.conv_port_oe_o(oe), .line_locked_clock_i(llc), .external_sample_clock_pin_i(extc),
		.conv_clock_o(cclk), .decoder_clamp_mode_i(cmode), .conv_clamp_o(clamp),
		.conv_ref_select_o(refsel), .source_switch_indicator_input_i(ind),
		.gain_loop_reset_o(glr), .gain_a_o(gain_a), .gain_b_o(gain_b),
		.pix_in_valid_i(vin), .pix_in_ready_o(irdy), .cvbs_luma_i(8'h55),
		.comp_luma_i(8'haa), .pixel_switch_input_i(sw), .pix_out_valid_o(oval),
		.pix_out_ready_i(ordy), .pix_out_data_o(odata), .pix_out_from_comp_o(ocomp));

	always #25 clk_sys_i = ~clk_sys_i;

	// Edge-time samples of the inputs and counts of handshakes
	always @(posedge clk_sys_i) begin
		llc_q <= llc;
		ext_q <= extc;
		cm_q <= cmode;
		if (glr === 1'b1)
			pulses = pulses + 1;
		if (vin && irdy === 1'b1)
			accepted = accepted + 1;
		if (oval === 1'b1 && ordy) begin
			outs = outs + 1;
			last_d = odata;
			last_c = ocomp;
		end
	end

	task give_verdict;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	task cmp(input string what, input [8:0] exp, input [8:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("MISMATCH %s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	task ticks(input integer n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task wreg(input [7:0] a, input [7:0] d);
		begin
			wr = 1'b1;
			addr = a;
			wdata = d;
			ticks(1);
			wr = 1'b0;
		end
	endtask

	// Read with bounded wait for the acknowledge, then compare
	task rdc(input [7:0] a, input [7:0] e);
		integer i;
		begin
			rd = 1'b1;
			addr = a;
			ticks(1);
			rd = 1'b0;
			for (i = 0; i < 4 && rack !== 1'b1; i = i + 1)
				ticks(1);
			if (i == 4) begin
				failures = failures + 1;
				give_verdict;
			end
			cmp("register read", {1'b0, e}, {1'b0, rdata});
		end
	endtask

	task t_regs;
		begin
			rdc(8'h23, 8'h00);
			rdc(8'h24, 8'h90);
			rdc(8'h25, 8'h90);
			rdc(8'h29, 8'h00);
			rdc(8'h2a, 8'h80);
			rdc(8'h2b, 8'h40);
			rdc(8'h30, 8'h00);
			cmp("gain a", 9'h090, gain_a);
		end
	endtask

	// Port enable, clock source and clamp choice, both settings
	task t_ctrl;
		integer k, i;
		begin
			for (k = 1; k >= 0; k = k - 1) begin
				wreg(8'h23, k ? 8'h70 : 8'h00);
				ticks(2);
				for (i = 0; i < 8; i = i + 1) begin
					cmp("port enable", k, oe);
					cmp("sample clock", k ? ext_q : llc_q, cclk);
					cmp("reference", k, refsel);
					cmp("clamp", k ? 1'b0 : cm_q, clamp);
					ticks(1);
				end
			end
		end
	endtask

	task t_gain;
		begin
			wreg(8'h23, 8'h03);
			wreg(8'h24, 8'h00);
			wreg(8'h25, 8'hff);
			ticks(1);
			cmp("gain a", 9'h100, gain_a);
			cmp("gain b", 9'h1ff, gain_b);
			rdc(8'h25, 8'hff);
			wreg(8'h23, 8'h00);
			ticks(1);
			cmp("gain a", 9'h000, gain_a);
		end
	endtask

	// Both edges of the indicator, enabled and then ignored
	task t_ind;
		integer k;
		begin
			for (k = 1; k >= 0; k = k - 1) begin
				wreg(8'h23, k ? 8'h04 : 8'h00);
				ticks(2);
				pulses = 0;
				ind = 1'b1;
				ticks(6);
				ind = 1'b0;
				ticks(6);
				cmp("gain loop resets", k ? 2 : 0, pulses);
			end
		end
	endtask

	// Stream a flat picture after setting the path, check the last pixel
	task prow(input [7:0] ctl, input [7:0] bri, input [7:0] con, input s,
		input [7:0] ed, input ec);
		integer a0, i;
		begin
			wreg(8'h29, ctl);
			wreg(8'h2a, bri);
			wreg(8'h2b, con);
			sw = s;
			a0 = accepted;
			vin = 1'b1;
			for (i = 0; i < 200 && accepted < a0 + 40; i = i + 1)
				ticks(1);
			vin = 1'b0;
			if (i == 200) begin
				failures = failures + 1;
				give_verdict;
			end
			ticks(12);
			cmp("pixel value", ed, last_d);
			cmp("pixel source", ec, last_c);
		end
	endtask

	task t_pix;
		begin
			prow(8'h00, 8'h80, 8'h40, 1'b1, 8'h55, 1'b0);
			prow(8'h80, 8'h80, 8'h40, 1'b1, 8'haa, 1'b1);
			prow(8'h80, 8'h80, 8'h40, 1'b0, 8'h55, 1'b0);
			prow(8'hc0, 8'h80, 8'h40, 1'b0, 8'haa, 1'b1);
			prow(8'hfb, 8'h80, 8'h40, 1'b0, 8'haa, 1'b1);
			prow(8'hc4, 8'h00, 8'h40, 1'b0, 8'h2a, 1'b1);
			prow(8'hc0, 8'hff, 8'h00, 1'b0, 8'h7f, 1'b1);
			prow(8'hc0, 8'h80, 8'h80, 1'b0, 8'h00, 1'b1);
			prow(8'hc0, 8'h80, 8'h7f, 1'b0, 8'hff, 1'b1);
		end
	endtask

	// Stalled sink fills the buffer; every taken beat comes out once
	task t_fill;
		integer a0, o0;
		begin
			ordy = 1'b0;
			a0 = accepted;
			o0 = outs;
			vin = 1'b1;
			ticks(20);
			cmp("input ready", 9'h000, irdy);
			vin = 1'b0;
			ticks(1);
			ordy = 1'b1;
			ticks(12);
			cmp("pixels out", accepted - a0, outs - o0);
		end
	endtask

	initial begin
		ticks(8);
		rst_n_i = 1'b1;
		ticks(2);
		t_regs;
		t_ctrl;
		t_gain;
		t_ind;
		t_pix;
		t_fill;
		give_verdict;
	end
endmodule
